// file: logic/bmp_pin_share.sv
`timescale 1ns/1ps
// How it works
// R1 - flash address on primary ata pins
// R2 - flash byte on secondary data pins
// R3 - read strobe da1, write strobe dd6
// R4 - memory select low selects boot memory
// R5 - eeprom data sel1, clock sel0
// R6 - class strap picks raid or ide class
// R7 - bar5 strap low reads zeroes
// R8 - scan enable puts flops in shift
// R9 - test mode selects test functions
// R10 - reset returns registers to initial values
// R11 - host inputs sampled on rising clock
// R12 - interrupt pulls low only, open drain
// R13 - interrupt from drive interrupt requests
// R14 - pins serve memory during auto init
// R15 - host accesses retried while loading
// R16 - one select steers every shared pin
module bmp_pin_share import bmp_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // loader and ata engines
  input wire bmp_mem_req_s mem_req,
  input wire bmp_ata_drv_s ata_drv,
  output logic [FL_DATA_W-1:0] fl_rdata,
  output logic [DD_W-1:0] s_dd_in,
  // drive interrupts
  input wire logic primary_drive_irq,
  input wire logic secondary_drive_irq,
  // straps and test pins
  input wire logic class_select_strap,
  input wire logic bar5_enable_strap,
  input wire logic scan_en_pin,
  input wire logic test_mode_pin,
  // host side status
  input wire logic host_access,
  input wire logic [31:0] bar5_raw,
  output logic host_retry,
  output logic [23:0] class_code,
  output logic [31:0] bar5_value,
  output logic scan_shift,
  output logic test_active,
  output logic host_irq_a_n_o,
  output logic host_irq_a_n_oe,
  // primary channel pins
  input wire logic [DD_W-1:0] primary_drive_data_i,
  output logic [DD_W-1:0] primary_drive_data_o,
  output logic primary_drive_data_oe,
  output logic primary_drive_addr0,
  output logic primary_drive_addr1,
  output logic primary_drive_addr2,
  output logic primary_drive_sel0_n,
  output logic primary_drive_sel1_n,
  // secondary channel pins
  input wire logic [DD_W-1:0] secondary_drive_data_i,
  output logic [DD_W-1:0] secondary_drive_data_o,
  output logic secondary_drive_data_oe,
  output logic secondary_drive_sel0_n,
  output logic secondary_drive_sel1_n,
  // boot memory select
  output logic mem_sel_n
);
  logic [5:0] pin_sync;
  logic [DD_W-1:0] s_dd_sync;
  logic boot_mode;
  logic [DD_W-1:0] fl_pdd;
  logic [FL_DATA_W-1:0] fl_sdd;
  logic [FL_DATA_W-1:0] fl_rd_map;
  logic [DD_W-1:0] pdd_next;
  logic pdd_oe_next;
  logic [DD_W-1:0] sdd_next;
  logic sdd_oe_next;
  logic da0_next;
  logic da1_next;
  logic da2_next;
  logic psel0_next;
  logic psel1_next;
  logic ssel0_next;
  logic ssel1_next;
  logic irq_next;
  logic [DD_W-1:0] pdd_reg;
  logic pdd_oe_reg;
  logic [DD_W-1:0] sdd_reg;
  logic sdd_oe_reg;
  logic da0_reg;
  logic da1_reg;
  logic da2_reg;
  logic psel0_reg;
  logic psel1_reg;
  logic ssel0_reg;
  logic ssel1_reg;
  logic memsel_reg;
  logic irq_oe_reg;
  logic retry_reg;
  logic [23:0] class_reg;
  logic [31:0] bar5_reg;
  logic scan_reg;
  logic test_reg;
  logic [FL_DATA_W-1:0] rdata_reg;
  logic [DD_W-1:0] sdd_in_reg;

  // strap and pin levels come from outside: two flops first
  bmp_sync #(.W(6)) u_pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d({class_select_strap, bar5_enable_strap, scan_en_pin, test_mode_pin,
        primary_drive_irq, secondary_drive_irq}),
    .q(pin_sync)
  ); // [R11]

  bmp_sync #(.W(DD_W)) u_dd_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(secondary_drive_data_i),
    .q(s_dd_sync)
  );

  assign boot_mode = mem_req.active; // [R16] [R14]

  // flash address onto primary data pins; dd6 carries write strobe
  // pin positions come from the package so the map lives in one place
  always_comb begin
    fl_pdd = '0;
    fl_pdd[A18_PIN] = mem_req.fl_addr[18]; // [R1]
    fl_pdd[A17_PIN] = mem_req.fl_addr[17];
    fl_pdd[A16_PIN] = mem_req.fl_addr[16];
    fl_pdd[A15_PIN] = mem_req.fl_addr[15];
    fl_pdd[A14_PIN] = mem_req.fl_addr[14];
    fl_pdd[A13_PIN] = mem_req.fl_addr[13];
    fl_pdd[A12_PIN] = mem_req.fl_addr[12];
    fl_pdd[A11_PIN] = mem_req.fl_addr[11];
    fl_pdd[A9_PIN] = mem_req.fl_addr[9];
    fl_pdd[A8_PIN] = mem_req.fl_addr[8];
    fl_pdd[A7_PIN] = mem_req.fl_addr[7];
    fl_pdd[A6_PIN] = mem_req.fl_addr[6];
    fl_pdd[A5_PIN] = mem_req.fl_addr[5];
    fl_pdd[A4_PIN] = mem_req.fl_addr[4];
    fl_pdd[A3_PIN] = mem_req.fl_addr[3];
    fl_pdd[WR_PIN] = ~mem_req.fl_wr; // [R3]
  end

  // byte lane mapping on secondary data pins
  assign fl_sdd = mem_req.fl_wdata; // [R2]
  assign fl_rd_map = {s_dd_sync[D7_PIN], s_dd_sync[D6_PIN], s_dd_sync[D5_PIN],
                      s_dd_sync[D4_PIN], s_dd_sync[D3_PIN], s_dd_sync[D2_PIN],
                      s_dd_sync[D1_PIN], s_dd_sync[D0_PIN]}; // [R2]

  always_comb begin
    pdd_next = ata_drv.p_dd_o;
    pdd_oe_next = ata_drv.p_dd_oe;
    da0_next = ata_drv.p_da0;
    da1_next = ata_drv.p_da1;
    da2_next = ata_drv.p_da2;
    psel0_next = ata_drv.p_sel0_n;
    psel1_next = ata_drv.p_sel1_n;
    sdd_next = ata_drv.s_dd_o;
    sdd_oe_next = ata_drv.s_dd_oe;
    ssel0_next = ata_drv.s_sel0_n;
    ssel1_next = ata_drv.s_sel1_n;
    if (boot_mode) begin // [R16]
      pdd_next = fl_pdd; // [R1]
      pdd_oe_next = 1'b1;
      da0_next = mem_req.fl_addr[2]; // [R1]
      da2_next = mem_req.fl_addr[10]; // [R1]
      psel0_next = mem_req.fl_addr[1]; // [R1]
      psel1_next = mem_req.fl_addr[0]; // [R1]
      da1_next = ~mem_req.fl_rd; // [R3]
      sdd_next = '0;
      sdd_next[D7_PIN] = fl_sdd[7];
      sdd_next[D6_PIN] = fl_sdd[6];
      sdd_next[D5_PIN] = fl_sdd[5];
      sdd_next[D4_PIN] = fl_sdd[4];
      sdd_next[D3_PIN] = fl_sdd[3];
      sdd_next[D2_PIN] = fl_sdd[2];
      sdd_next[D1_PIN] = fl_sdd[1];
      sdd_next[D0_PIN] = fl_sdd[0];
      sdd_oe_next = mem_req.fl_wr; // [R2] memory drives on reads
      ssel0_next = mem_req.ee_clk; // [R5]
      ssel1_next = mem_req.ee_data; // [R5]
    end
  end

  // irq asserted while either synced drive request is high
  assign irq_next = pin_sync[1] | pin_sync[0]; // [R13]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin // [R10]
      pdd_reg <= '0;
      pdd_oe_reg <= 1'b0;
      da0_reg <= 1'b0;
      da1_reg <= 1'b1;
      da2_reg <= 1'b0;
      psel0_reg <= 1'b1;
      psel1_reg <= 1'b1;
      sdd_reg <= '0;
      sdd_oe_reg <= 1'b0;
      ssel0_reg <= 1'b1;
      ssel1_reg <= 1'b1;
      memsel_reg <= 1'b1;
      irq_oe_reg <= 1'b0;
      retry_reg <= 1'b0;
    end else begin
      pdd_reg <= pdd_next;
      pdd_oe_reg <= pdd_oe_next;
      da0_reg <= da0_next;
      da1_reg <= da1_next;
      da2_reg <= da2_next;
      psel0_reg <= psel0_next;
      psel1_reg <= psel1_next;
      sdd_reg <= sdd_next;
      sdd_oe_reg <= sdd_oe_next;
      ssel0_reg <= ssel0_next;
      ssel1_reg <= ssel1_next;
      memsel_reg <= ~(boot_mode & mem_req.fl_sel); // [R4]
      irq_oe_reg <= irq_next; // [R12]
      retry_reg <= boot_mode & host_access; // [R15]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin // [R10]
      class_reg <= CLASS_IDE;
      bar5_reg <= BAR5_OFF;
      scan_reg <= 1'b0;
      test_reg <= 1'b0;
      rdata_reg <= '0;
      sdd_in_reg <= '0;
    end else begin
      class_reg <= pin_sync[5] ? CLASS_IDE : CLASS_RAID; // [R6]
      bar5_reg <= pin_sync[4] ? bar5_raw : BAR5_OFF; // [R7]
      scan_reg <= pin_sync[3]; // [R8]
      test_reg <= pin_sync[2]; // [R9]
      rdata_reg <= fl_rd_map; // [R2]
      sdd_in_reg <= s_dd_sync;
    end
  end

  assign primary_drive_data_o = pdd_reg;
  assign primary_drive_data_oe = pdd_oe_reg;
  assign primary_drive_addr0 = da0_reg;
  assign primary_drive_addr1 = da1_reg;
  assign primary_drive_addr2 = da2_reg;
  assign primary_drive_sel0_n = psel0_reg;
  assign primary_drive_sel1_n = psel1_reg;
  assign secondary_drive_data_o = sdd_reg;
  assign secondary_drive_data_oe = sdd_oe_reg;
  assign secondary_drive_sel0_n = ssel0_reg;
  assign secondary_drive_sel1_n = ssel1_reg;
  assign mem_sel_n = memsel_reg;
  // open drain: output level fixed low, only enable moves
  assign host_irq_a_n_o = 1'b0; // [R12]
  assign host_irq_a_n_oe = irq_oe_reg;
  assign host_retry = retry_reg;
  assign class_code = class_reg;
  assign bar5_value = bar5_reg;
  assign scan_shift = scan_reg;
  assign test_active = test_reg;
  assign fl_rdata = rdata_reg;
  assign s_dd_in = sdd_in_reg;
endmodule

// file: logic/bmp_pkg.sv
package bmp_pkg;
  localparam int FL_ADDR_W = 19;
  localparam int FL_DATA_W = 8;
  localparam int DD_W = 16;
  localparam int STRAP_SYNC = 2;
  localparam logic [23:0] CLASS_RAID = 24'h010400;
  localparam logic [23:0] CLASS_IDE = 24'h010185;
  localparam logic [31:0] BAR5_OFF = 32'h0000_0000;
  // flash address bit -> primary data pin index (bits 18..11, 9..3)
  localparam int A18_PIN = 7;
  localparam int A17_PIN = 5;
  localparam int A16_PIN = 8;
  localparam int A15_PIN = 9;
  localparam int A14_PIN = 4;
  localparam int A13_PIN = 3;
  localparam int A12_PIN = 10;
  localparam int A11_PIN = 0;
  localparam int A9_PIN = 1;
  localparam int A8_PIN = 2;
  localparam int A7_PIN = 11;
  localparam int A6_PIN = 12;
  localparam int A5_PIN = 13;
  localparam int A4_PIN = 14;
  localparam int A3_PIN = 15;
  localparam int WR_PIN = 6;
  // flash data bit -> secondary data pin index
  localparam int D7_PIN = 7;
  localparam int D6_PIN = 6;
  localparam int D5_PIN = 5;
  localparam int D4_PIN = 4;
  localparam int D3_PIN = 11;
  localparam int D2_PIN = 10;
  localparam int D1_PIN = 9;
  localparam int D0_PIN = 8;

  // boot memory request from the loader
  typedef struct packed {
    logic active;
    logic fl_sel;
    logic fl_rd;
    logic fl_wr;
    logic [FL_ADDR_W-1:0] fl_addr;
    logic [FL_DATA_W-1:0] fl_wdata;
    logic ee_clk;
    logic ee_data;
  } bmp_mem_req_s;

  // normal ata pin drive from the channel engines
  typedef struct packed {
    logic [DD_W-1:0] p_dd_o;
    logic p_dd_oe;
    logic p_da0;
    logic p_da1;
    logic p_da2;
    logic p_sel0_n;
    logic p_sel1_n;
    logic [DD_W-1:0] s_dd_o;
    logic s_dd_oe;
    logic s_sel0_n;
    logic s_sel1_n;
  } bmp_ata_drv_s;
endpackage

// file: logic/bmp_sync.sv
`timescale 1ns/1ps
module bmp_sync import bmp_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// file: tb/bmp_flash_model.sv
`timescale 1ns/1ps
module bmp_flash_model import bmp_pkg::*; (
  // memory pins
  input wire logic sys_clk,
  input wire logic mem_sel_n,
  input wire logic rd_n,
  input wire logic [18:0] addr,
  output logic [DD_W-1:0] sdd
);
  logic [7:0] b = 8'h00;
  // released bus toggles so a stale byte is never held steady
  always @(posedge sys_clk) begin
    b = (!mem_sel_n && !rd_n) ? addr[7:0] : ~b;
    sdd <= {4'h0, b[3:0], b[7:4], 4'h0};
  end
endmodule

// file: tb/bmp_pin_share_assertions.sv
`timescale 1ns/1ps
module bmp_pin_share_chk import bmp_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // watched ports
  input wire bmp_mem_req_s mem_req,
  input wire bmp_ata_drv_s ata_drv,
  input wire logic host_access,
  input wire logic class_select_strap,
  input wire logic bar5_enable_strap,
  input wire logic primary_drive_irq,
  input wire logic host_retry,
  input wire logic [23:0] class_code,
  input wire logic [31:0] bar5_value,
  input wire logic host_irq_a_n_o,
  input wire logic host_irq_a_n_oe,
  input wire logic [DD_W-1:0] primary_drive_data_o,
  input wire logic primary_drive_addr1,
  input wire logic primary_drive_sel1_n,
  input wire logic secondary_drive_sel0_n,
  input wire logic mem_sel_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // four samples cover the two sync flops and the output register
  sequence s_held(x);
    x [*4];
  endsequence
  a_addr_pins: assert property ($past(mem_req.active) |->
    primary_drive_sel1_n == $past(mem_req.fl_addr[0])
    && primary_drive_data_o[A18_PIN] == $past(mem_req.fl_addr[18])) else $error("address pin");
  a_read_strobe: assert property ($past(mem_req.active) |->
    primary_drive_addr1 == !$past(mem_req.fl_rd)
    && primary_drive_data_o[WR_PIN] == !$past(mem_req.fl_wr)) else $error("strobe pin");
  a_mem_select: assert property (
    !mem_sel_n == $past(mem_req.active && mem_req.fl_sel)) else $error("memory select");
  a_eeprom_clock: assert property ($past(mem_req.active) |->
    secondary_drive_sel0_n == $past(mem_req.ee_clk)) else $error("eeprom clock");
  a_raid_class: assert property (s_held(!class_select_strap) |->
    class_code == CLASS_RAID) else $error("class code");
  a_bar5_off: assert property (s_held(!bar5_enable_strap) |->
    bar5_value == BAR5_OFF) else $error("bar5 not zero");
  a_retry_boot: assert property (
    host_retry == $past(mem_req.active && host_access)) else $error("retry");
  a_irq_low_only: assert property (!host_irq_a_n_o) else $error("irq driven high");
  a_irq_cause: assert property (s_held(primary_drive_irq) |->
    host_irq_a_n_oe) else $error("irq missing");
  a_ata_pass: assert property (!$past(mem_req.active) |->
    primary_drive_data_o == $past(ata_drv.p_dd_o)) else $error("ata data");
endmodule
bind bmp_pin_share bmp_pin_share_chk chk_u (.*);

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench import bmp_pkg::*;;
  logic sys_clk = 0, rstn = 0, primary_drive_irq = 0, secondary_drive_irq = 0, host_access = 0;
  logic class_select_strap = 0, bar5_enable_strap = 1, scan_en_pin = 0, test_mode_pin = 0;
  logic [31:0] bar5_raw = 32'h0, bar5_value;
  bmp_mem_req_s mem_req = '0;
  bmp_ata_drv_s ata_drv = '0;
  logic [7:0] fl_rdata;
  logic [DD_W-1:0] s_dd_in, primary_drive_data_o, secondary_drive_data_o, sm;
  logic host_retry, scan_shift, test_active, host_irq_a_n_o, host_irq_a_n_oe, mem_sel_n;
  logic [23:0] class_code;
  logic primary_drive_data_oe, primary_drive_addr0, primary_drive_addr1, primary_drive_addr2;
  logic primary_drive_sel0_n, primary_drive_sel1_n, secondary_drive_data_oe;
  logic secondary_drive_sel0_n, secondary_drive_sel1_n;
  int num_errors = 0, checks = 0, cyc = 0;
  wire [DD_W-1:0] p = primary_drive_data_o;
  wire [DD_W-1:0] primary_drive_data_i = primary_drive_data_oe ? p : ~p;
  wire [DD_W-1:0] secondary_drive_data_i = secondary_drive_data_oe ? secondary_drive_data_o : sm;
  wire [18:0] fa = {p[7], p[5], p[8], p[9], p[4], p[3], p[10], p[0], primary_drive_addr2,
    p[1], p[2], p[11], p[12], p[13], p[14], p[15], primary_drive_addr0,
    primary_drive_sel0_n, primary_drive_sel1_n};
  bmp_pin_share dut_u (.*);
  bmp_flash_model mem_u (.sys_clk, .mem_sel_n, .rd_n(primary_drive_addr1), .addr(fa), .sdd(sm));
  always #12.5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_read(input logic [18:0] a);
    @(posedge sys_clk);
    mem_req <= '{active: 1'b1, fl_sel: 1'b1, fl_rd: 1'b1, fl_addr: a, default: '0};
    cy(2);
    chk(fa, a);
    chk(primary_drive_addr1, 0);
    chk(mem_sel_n, 0);
    cy(5);
    chk(fl_rdata, a[7:0]);
    @(posedge sys_clk);
    mem_req <= '{active: 1'b1, default: '0};
    cy(2);
    chk(mem_sel_n, 1);
  endtask
  task automatic t_write(input logic [7:0] d);
    @(posedge sys_clk);
    mem_req <= '{active: 1'b1, fl_sel: 1'b1, fl_wr: 1'b1, fl_wdata: d, default: '0};
    cy(2);
    chk(secondary_drive_data_oe, 1);
    chk({secondary_drive_data_o[7:4], secondary_drive_data_o[11:8]}, d);
    chk({p[6], primary_drive_addr1}, 2'b01);
  endtask
  task automatic t_eeprom();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      mem_req <= '{active: 1'b1, ee_clk: i[0], ee_data: i[1], default: '0};
      cy(2);
      chk({secondary_drive_sel1_n, secondary_drive_sel0_n}, i[1:0]);
    end
  endtask
  task automatic t_ata_retry();
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk);
      mem_req <= '{active: b[0], default: '0};
      ata_drv <= '{p_dd_o: 16'h1234, s_dd_o: 16'hBEEF, s_sel0_n: 1'b1, default: '0};
      host_access <= 1;
      cy(2);
      chk(host_retry, b[0]);
      chk(primary_drive_addr1, b[0]);
      chk(secondary_drive_sel0_n, !b[0]);
    end
    chk(p, 16'h1234);
    chk(secondary_drive_data_o, 16'hBEEF);
    @(posedge sys_clk);
    host_access <= 0;
  endtask
  task automatic t_strap(input logic v);
    @(posedge sys_clk);
    {class_select_strap, bar5_enable_strap, scan_en_pin, test_mode_pin} <= {4{v}};
    bar5_raw <= 32'hCAFE0001;
    cy(5);
    chk(class_code, v ? CLASS_IDE : CLASS_RAID);
    chk(bar5_value, v ? 32'hCAFE0001 : BAR5_OFF);
    chk(scan_shift, v);
    chk(test_active, v);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {secondary_drive_irq, primary_drive_irq} <= i[1:0];
      cy(5);
      chk(host_irq_a_n_oe, |i[1:0]);
      chk(host_irq_a_n_o, 0);
    end
  endtask
  initial begin
    cy(2);
    chk(mem_sel_n, 1);
    chk(class_code, CLASS_IDE);
    chk(primary_drive_data_oe, 0);
    @(posedge sys_clk);
    rstn <= 1;
    t_read(19'h7FFFF);
    t_read(19'h00000);
    t_read(19'h2C3B4);
    t_write(8'hA5);
    t_eeprom();
    t_ata_retry();
    t_strap(0);
    t_strap(1);
    t_irq();
    stop_test();
  end
endmodule
